// ==== rtlr_consts.svh ====
// Register offsets, reset values, field positions and fixed values of the remote channel
`ifndef RTLR_CONSTS_SVH
`define RTLR_CONSTS_SVH
`define RTLR_A_TEMP_INT   8'h01
`define RTLR_A_HIGH_INT   8'h07
`define RTLR_A_LOW_INT    8'h08
`define RTLR_A_TEMP_FRAC  8'h10
`define RTLR_A_OFF_INT    8'h11
`define RTLR_A_OFF_FRAC   8'h12
`define RTLR_A_HIGH_FRAC  8'h13
`define RTLR_A_LOW_FRAC   8'h14
`define RTLR_A_CRIT       8'h19
`define RTLR_A_HYST       8'h21
`define RTLR_A_CFG        8'hBF
`define RTLR_RST_HIGH_INT 8'h46
`define RTLR_RST_ZERO     8'h00
`define RTLR_RST_CRIT     8'h55
`define RTLR_RST_HYST     8'h0A
`define RTLR_RST_TEMP     11'h000
`define RTLR_CFG_MODE_BIT 0
`define RTLR_CFG_FILT_LO  1
`define RTLR_CFG_FILT_HI  2
`define RTLR_FRAC_HI      7
`define RTLR_FRAC_LO      5
`define RTLR_REPORT_NEG   11'h780
`define RTLR_TEMP_MAX     11'h3FF
`define RTLR_TEMP_MIN     11'h400
`define RTLR_FILT_MIN_SH  1
`define RTLR_FILT_MAX_SH  3
`endif

// ==== rtlr_pkg.sv ====
// Shared types and saturating arithmetic of the remote temperature channel
`include "rtlr_consts.svh"
package rtlr_pkg;
  typedef logic signed [10:0] rtlr_temp_t;
  typedef enum logic [1:0] {
    RTLR_FILT_OFF   = 2'h0,
    RTLR_FILT_MIN_A = 2'h1,
    RTLR_FILT_MIN_B = 2'h2,
    RTLR_FILT_MAX   = 2'h3
  } rtlr_filt_t;
  typedef enum logic {RTLR_AL_IDLE, RTLR_AL_HELD} rtlr_alert_st_t;

  // Saturating add, so an offset never wraps a hot reading to a cold one
  function automatic rtlr_temp_t rtlr_sat_add(input rtlr_temp_t a, input rtlr_temp_t b);
    logic signed [11:0] s;
    s = {a[10], a} + {b[10], b};
    if (s[11] != s[10]) begin
      return s[11] ? rtlr_temp_t'(`RTLR_TEMP_MIN) : rtlr_temp_t'(`RTLR_TEMP_MAX);
    end
    return s[10:0];
  endfunction : rtlr_sat_add
endpackage : rtlr_pkg

// ==== rtlr_filter.sv ====
// Reading filter: pass-through, light or heavy exponential smoothing
`timescale 1ns/100ps
module rtlr_filter
  import rtlr_pkg::*;
(
  input  wire logic       sys_clk,      // System clock
  input  wire logic       reset,        // Synchronous reset
  input  wire logic       ce,           // Clock enable
  input  wire logic       sample_valid, // New converter sample
  input  wire rtlr_temp_t sample,       // Converter sample
  input  wire rtlr_filt_t mode,         // Filter selection
  output logic            out_valid,    // Filtered value ready
  output rtlr_temp_t      out_temp      // Filtered value
);
  logic signed [13:0] acc, next_acc;
  logic               primed, next_primed;
  logic               next_valid;
  logic signed [14:0] diff;

  // Three extra fraction bits keep heavy smoothing from stalling short of the input
  always_comb begin
    next_acc    = acc;
    next_primed = primed;
    next_valid  = 1'b0;
    diff        = {sample[10], sample, 3'h0} - {acc[13], acc};
    if (sample_valid) begin
      next_valid  = 1'b1;
      next_primed = 1'b1;
      unique case (mode)
        RTLR_FILT_OFF:                   next_acc = {sample, 3'h0};              // R9
        RTLR_FILT_MIN_A, RTLR_FILT_MIN_B: next_acc = acc + 14'(diff >>> `RTLR_FILT_MIN_SH); // R9
        RTLR_FILT_MAX:                   next_acc = acc + 14'(diff >>> `RTLR_FILT_MAX_SH); // R9
      endcase
      if (!primed) begin
        next_acc = {sample, 3'h0};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      acc       <= 14'h0000;
      primed    <= 1'b0;
      out_valid <= 1'b0;
    end else if (ce) begin
      acc       <= next_acc;
      primed    <= next_primed;
      out_valid <= next_valid;
    end
  end

  assign out_temp = acc[13:3];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_filter_bypass: assert property (ce && sample_valid && mode == RTLR_FILT_OFF |=> out_temp == $past(sample)) // R9
    else $error("unfiltered sample not passed through");
  cov_filter_max: cover property (ce && sample_valid && primed && mode == RTLR_FILT_MAX);
endmodule : rtlr_filter

// ==== rtlr_alarm.sv ====
// Limit comparisons, critical hysteresis and alert pin modes
`timescale 1ns/100ps
module rtlr_alarm
  import rtlr_pkg::*;
(
  input  wire logic       sys_clk,    // System clock
  input  wire logic       reset,      // Synchronous reset
  input  wire logic       ce,         // Clock enable
  input  wire rtlr_temp_t temp,       // Stored reading
  input  wire rtlr_temp_t high_lim,   // High setpoint
  input  wire rtlr_temp_t low_lim,    // Low setpoint
  input  wire logic [7:0] crit_lim,   // Critical limit
  input  wire logic [7:0] crit_hyst,  // Critical hysteresis
  input  wire logic       comp_mode,  // 1 comparator, 0 interrupt
  input  wire logic       alert_ack,  // Alert response pulse
  output logic            high_alarm, // Above high setpoint
  output logic            low_alarm,  // Below low setpoint
  output logic            crit_alarm, // Critical, with hysteresis
  output logic            alert_oe    // Alert pin pulled low
);
  logic signed [12:0] t13, trip13, rel13;
  logic [8:0]         rel9;
  logic               next_high, next_low, next_crit, next_oe, any, any_q;
  rtlr_alert_st_t     st, next_st;

  // Limit compares; critical releases only below limit minus hysteresis
  always_comb begin
    t13       = 13'(temp);
    trip13    = {{2{crit_lim[7]}}, crit_lim, 3'h0};
    rel9      = {crit_lim[7], crit_lim} - {crit_hyst[7], crit_hyst};
    rel13     = {rel9[8], rel9, 3'h0};
    next_high = temp > high_lim;                                  // R13
    next_low  = temp < low_lim;                                   // R14
    next_crit = crit_alarm ? !(t13 < rel13) : (t13 > trip13);     // R8
    any       = high_alarm || low_alarm || crit_alarm;
    next_st   = st;
    unique case (st)
      RTLR_AL_IDLE: if (any && !any_q) next_st = RTLR_AL_HELD;    // R11
      RTLR_AL_HELD: if (alert_ack && !(any && !any_q)) next_st = RTLR_AL_IDLE;
    endcase
    next_oe = comp_mode ? any : (next_st == RTLR_AL_HELD);        // R10 R11
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      high_alarm <= 1'b0;
      low_alarm  <= 1'b0;
      crit_alarm <= 1'b0;
      any_q      <= 1'b0;
      st         <= RTLR_AL_IDLE;
      alert_oe   <= 1'b0;
    end else if (ce) begin
      high_alarm <= next_high;
      low_alarm  <= next_low;
      crit_alarm <= next_crit;
      any_q      <= any;
      st         <= next_st;
      alert_oe   <= next_oe;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_high_alarm_set: assert property (ce && temp > high_lim |=> high_alarm) // R13
    else $error("high alarm missed");
  a_low_alarm_set: assert property (ce && temp < low_lim |=> low_alarm) // R14
    else $error("low alarm missed");
  a_crit_hyst_hold: assert property (ce && crit_alarm && !(t13 < rel13) |=> crit_alarm) // R8
    else $error("critical released above hysteresis point");
  a_comp_alert_follow: assert property (ce && comp_mode |=> alert_oe == $past(any)) // R10
    else $error("comparator alert does not follow condition");
  a_int_alert_latch: assert property (ce && !comp_mode && st == RTLR_AL_HELD && !alert_ack |=> alert_oe) // R11
    else $error("interrupt alert dropped without response");
  cov_crit_set: cover property (!crit_alarm ##1 crit_alarm);
  cov_int_ack: cover property (!comp_mode && alert_oe ##1 alert_ack ##1 !alert_oe);
endmodule : rtlr_alarm

// ==== rtlr_regs.sv ====
// Remote temperature reading, offset, setpoint, critical and mode registers
`timescale 1ns/100ps
// Notes on behaviour
// R1: Integer byte is signed whole degrees
// R2: Fraction bits 7:5 eighths; 4:0 read zero
// R3: Reading is reported 16 degrees low
// R4: Signed offset added to each converter result
// R5: High setpoint resets to 70.0 degrees
// R6: Low setpoint resets to zero
// R7: Critical limit resets to 85, always writable
// R8: Critical holds until below limit minus hysteresis
// R9: Filter field selects none, light, heavy
// R10: Mode 1 makes alert a comparator
// R11: Mode 0 latches alert until response
// R12: Host writes zero to configuration bits 7:3
// R13: Above high setpoint sets high alarm
// R14: Below low setpoint sets low alarm
// R15: Integer read captures fraction for later read
module rtlr_regs
  import rtlr_pkg::*;
(
  input  wire logic        sys_clk,    // System clock, 200 MHz
  input  wire logic        reset,      // Synchronous reset, active high
  input  wire logic        ce,         // Clock enable, freezes all state
  input  wire logic        adc_valid,  // Converter result strobe
  input  wire rtlr_temp_t  adc_temp,   // Converter result, 1/8 degree
  input  wire logic [7:0]  reg_addr,   // Register address
  input  wire logic        reg_wr,     // Register write strobe
  input  wire logic        reg_rd,     // Register read strobe
  input  wire logic [7:0]  reg_wdata,  // Write data
  input  wire logic        alert_ack,  // Alert response pulse
  output logic      [7:0]  reg_rdata,  // Read data
  output logic             reg_rvalid, // Read data valid pulse
  output logic             high_alarm, // Above high setpoint
  output logic             low_alarm,  // Below low setpoint
  output logic             crit_alarm, // Critical condition
  output logic             alert_oe    // Alert pin drive low
);
  rtlr_temp_t  temp, next_temp;
  logic [7:0]  high_int, next_high_int;
  logic [2:0]  high_frac, next_high_frac;
  logic [7:0]  low_int, next_low_int;
  logic [2:0]  low_frac, next_low_frac;
  logic [7:0]  off_int, next_off_int;
  logic [2:0]  off_frac, next_off_frac;
  logic [7:0]  crit, next_crit;
  logic [7:0]  hyst, next_hyst;
  logic [2:0]  cfg, next_cfg;
  logic [7:0]  frac_snap, next_frac_snap;
  logic [7:0]  next_rdata;
  logic        next_rvalid;
  logic        filt_valid;
  rtlr_temp_t  filt_temp;
  rtlr_temp_t  offset;
  logic [7:0]  temp_int;
  logic [7:0]  temp_frac;

  // Byte views of the stored reading
  assign offset    = {off_int, off_frac};
  assign temp_int  = temp[10:3];                                   // R1
  assign temp_frac = {temp[2:0], 5'h00};                           // R2

  // Smoothing sits before the offset so a new offset takes effect at once
  rtlr_filter u_filter (
    .sys_clk      (sys_clk),
    .reset        (reset),
    .ce           (ce),
    .sample_valid (adc_valid),
    .sample       (adc_temp),
    .mode         (rtlr_filt_t'(cfg[`RTLR_CFG_FILT_HI:`RTLR_CFG_FILT_LO])),
    .out_valid    (filt_valid),
    .out_temp     (filt_temp)
  );

  // Limits are compared against the stored, offset-corrected reading
  rtlr_alarm u_alarm (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .ce         (ce),
    .temp       (temp),
    .high_lim   ({high_int, high_frac}),
    .low_lim    ({low_int, low_frac}),
    .crit_lim   (crit),
    .crit_hyst  (hyst),
    .comp_mode  (cfg[`RTLR_CFG_MODE_BIT]),
    .alert_ack  (alert_ack),
    .high_alarm (high_alarm),
    .low_alarm  (low_alarm),
    .crit_alarm (crit_alarm),
    .alert_oe   (alert_oe)
  );

  // Reading update: filtered result plus offset, then shifted down by 16 degrees
  always_comb begin
    next_temp = temp;
    if (filt_valid) begin
      next_temp = rtlr_sat_add(rtlr_sat_add(filt_temp, offset), rtlr_temp_t'(`RTLR_REPORT_NEG)); // R3 R4
    end
  end

  // Host writes; the reading and its fraction are read only
  always_comb begin
    next_high_int  = high_int;
    next_high_frac = high_frac;
    next_low_int   = low_int;
    next_low_frac  = low_frac;
    next_off_int   = off_int;
    next_off_frac  = off_frac;
    next_crit      = crit;
    next_hyst      = hyst;
    next_cfg       = cfg;
    if (reg_wr) begin
      case (reg_addr)
        `RTLR_A_HIGH_INT:  next_high_int  = reg_wdata;             // R5
        `RTLR_A_HIGH_FRAC: next_high_frac = reg_wdata[`RTLR_FRAC_HI:`RTLR_FRAC_LO];
        `RTLR_A_LOW_INT:   next_low_int   = reg_wdata;             // R6
        `RTLR_A_LOW_FRAC:  next_low_frac  = reg_wdata[`RTLR_FRAC_HI:`RTLR_FRAC_LO];
        `RTLR_A_OFF_INT:   next_off_int   = reg_wdata;             // R4
        `RTLR_A_OFF_FRAC:  next_off_frac  = reg_wdata[`RTLR_FRAC_HI:`RTLR_FRAC_LO];
        `RTLR_A_CRIT:      next_crit      = reg_wdata;             // R7
        `RTLR_A_HYST:      next_hyst      = reg_wdata;             // R8
        `RTLR_A_CFG:       next_cfg       = reg_wdata[2:0];        // R12
        default: ;
      endcase
    end
  end

  // Host reads; an integer read freezes the matching fraction
  always_comb begin
    next_rdata     = reg_rdata;
    next_rvalid    = 1'b0;
    next_frac_snap = frac_snap;
    if (reg_rd) begin
      next_rvalid = 1'b1;
      case (reg_addr)
        `RTLR_A_TEMP_INT: begin
          next_rdata     = temp_int;                               // R1
          next_frac_snap = temp_frac;                              // R15
        end
        `RTLR_A_TEMP_FRAC: next_rdata = frac_snap;                 // R2 R15
        `RTLR_A_HIGH_INT:  next_rdata = high_int;
        `RTLR_A_HIGH_FRAC: next_rdata = {high_frac, 5'h00};
        `RTLR_A_LOW_INT:   next_rdata = low_int;
        `RTLR_A_LOW_FRAC:  next_rdata = {low_frac, 5'h00};
        `RTLR_A_OFF_INT:   next_rdata = off_int;
        `RTLR_A_OFF_FRAC:  next_rdata = {off_frac, 5'h00};
        `RTLR_A_CRIT:      next_rdata = crit;
        `RTLR_A_HYST:      next_rdata = hyst;
        `RTLR_A_CFG:       next_rdata = {5'h00, cfg};              // R12
        default:           next_rdata = 8'h00;
      endcase
    end
  end

  // Register stage; frozen whenever ce is low
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      temp       <= `RTLR_RST_TEMP;
      high_int   <= `RTLR_RST_HIGH_INT;                            // R5
      high_frac  <= 3'h0;
      low_int    <= `RTLR_RST_ZERO;                                // R6
      low_frac   <= 3'h0;
      off_int    <= `RTLR_RST_ZERO;
      off_frac   <= 3'h0;
      crit       <= `RTLR_RST_CRIT;                                // R7
      hyst       <= `RTLR_RST_HYST;                                // R8
      cfg        <= 3'h0;                                          // R11
      frac_snap  <= `RTLR_RST_ZERO;
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      temp       <= next_temp;
      high_int   <= next_high_int;
      high_frac  <= next_high_frac;
      low_int    <= next_low_int;
      low_frac   <= next_low_frac;
      off_int    <= next_off_int;
      off_frac   <= next_off_frac;
      crit       <= next_crit;
      hyst       <= next_hyst;
      cfg        <= next_cfg;
      frac_snap  <= next_frac_snap;
      reg_rdata  <= next_rdata;
      reg_rvalid <= next_rvalid;
    end
  end

  // Independent model of the stored reading, for checking only: clipped after the offset, again after the shift
  logic signed [12:0] exp_sum;
  rtlr_temp_t         exp_temp;
  always_comb begin
    exp_sum = 13'(filt_temp) + 13'(offset);
    if (exp_sum > 13'sd1023) begin
      exp_sum = 13'sd1023;
    end else if (exp_sum < -13'sd1024) begin
      exp_sum = -13'sd1024;
    end
    exp_sum = exp_sum - 13'sd128;
    if (exp_sum < -13'sd1024) begin
      exp_temp = rtlr_temp_t'(`RTLR_TEMP_MIN);
    end else begin
      exp_temp = exp_sum[10:0];
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_reading_offset: assert property (ce && filt_valid |=> temp == $past(exp_temp)) // R3
    else $error("stored reading differs from offset-corrected result");
  a_offset_write_use: assert property (ce && reg_wr && reg_addr == `RTLR_A_OFF_INT |=> offset[10:3] == $past(reg_wdata)) // R4
    else $error("new offset not applied");
  a_int_byte_read: assert property (ce && reg_rd && reg_addr == `RTLR_A_TEMP_INT |=> reg_rvalid && reg_rdata == $past(temp_int)) // R1
    else $error("integer byte read wrong");
  a_frac_low_zero: assert property (ce && reg_rd && reg_addr == `RTLR_A_TEMP_FRAC |=> reg_rdata[4:0] == 5'h00) // R2
    else $error("fraction low bits not zero");
  a_frac_snapshot: assert property (ce && reg_rd && reg_addr == `RTLR_A_TEMP_INT // R15
    ##1 ce && !(reg_rd && reg_addr == `RTLR_A_TEMP_INT)
    ##1 ce && reg_rd && reg_addr == `RTLR_A_TEMP_FRAC |=> reg_rdata == $past(temp_frac, 3))
    else $error("fraction read not coherent");
  a_snap_capture: assert property (ce && reg_rd && reg_addr == `RTLR_A_TEMP_INT |=> frac_snap == $past(temp_frac)) // R15
    else $error("fraction not captured on integer read");
  a_reset_values: assert property ($fell(reset) |-> high_int == 8'h46 && {high_frac, low_int, low_frac} == 14'h0000 // R5
    && crit == 8'h55 && hyst == 8'h0A && cfg == 3'h0)
    else $error("reset values wrong");
  a_crit_writable: assert property (ce && reg_wr && reg_addr == `RTLR_A_CRIT |=> crit == $past(reg_wdata)) // R7
    else $error("critical limit write lost");
  a_cfg_high_zero: assert property (ce && reg_rd && reg_addr == `RTLR_A_CFG |=> reg_rdata[7:3] == 5'h00) // R12
    else $error("configuration upper bits not zero");
  a_freeze_ce: assert property (!ce |=> $stable(temp) && $stable(reg_rvalid) && $stable(crit))
    else $error("state moved with ce low");

  cov_snap_pair: cover property (reg_rd && reg_addr == `RTLR_A_TEMP_INT ##[1:4] reg_rd && reg_addr == `RTLR_A_TEMP_FRAC);
  cov_high_alarm: cover property (!high_alarm ##1 high_alarm);
  cov_comp_mode: cover property (reg_wr && reg_addr == `RTLR_A_CFG && reg_wdata[0]);
endmodule : rtlr_regs

// ==== rtlr_host_model.sv ====
// Host-side model of the register strobe port, standing in for the management bus master
`timescale 1ns/100ps
`include "rtlr_consts.svh"
module rtlr_host_model (
  input  wire logic       sys_clk,    // System clock
  input  wire logic [7:0] reg_rdata,  // Read data
  input  wire logic       reg_rvalid, // Read data valid
  output logic      [7:0] reg_addr,   // Register address
  output logic            reg_wr,     // Write strobe
  output logic            reg_rd,     // Read strobe
  output logic      [7:0] reg_wdata   // Write data
);
  // Idle bus at time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end

  // One strobe cycle; afterwards address and data flip so a stale value never looks valid
  task automatic strobe(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge sys_clk);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = w;
    reg_rd    = !w;
    @(posedge sys_clk);
    #1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : strobe

  // Unused configuration bits always go out as zero
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    strobe(a, (a == `RTLR_A_CFG) ? (d & 8'h07) : d, 1'b1);
  endtask : wr

  // Read, with a short bounded wait for the valid pulse
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    int n;
    strobe(a, 8'h00, 1'b0);
    n = 0;
    while (reg_rvalid !== 1'b1 && n < 4) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    ok = (reg_rvalid === 1'b1);
    d  = reg_rdata;
  endtask : rd
endmodule : rtlr_host_model

// ==== rtlr_regs_tb.sv ====
// Self-checking bench of the remote temperature register block
`timescale 1ns/100ps
`include "rtlr_consts.svh"
module rtlr_regs_tb import rtlr_pkg::*;;
  logic       sys_clk   = 1'b0;
  logic       reset     = 1'b1;
  logic       ce        = 1'b1;
  logic       adc_valid = 1'b0;
  rtlr_temp_t adc_temp  = 11'h000;
  logic       alert_ack = 1'b0;
  logic [7:0] reg_addr, reg_rdata, reg_wdata;
  logic       reg_wr, reg_rd, reg_rvalid, high_alarm, low_alarm, crit_alarm, alert_oe;
  logic [10:0] e;
  int         n_errors  = 0;
  int         n_checks  = 0;
  int         cyc       = 0;
  localparam logic [7:0] RA [9] = '{`RTLR_A_HIGH_INT, `RTLR_A_LOW_INT, `RTLR_A_OFF_INT, `RTLR_A_OFF_FRAC,
    `RTLR_A_HIGH_FRAC, `RTLR_A_LOW_FRAC, `RTLR_A_CRIT, `RTLR_A_HYST, `RTLR_A_CFG};
  localparam logic [7:0] RV [9] = '{8'h46, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h55, 8'h0A, 8'h00};
  localparam logic [7:0] RM [9] = '{8'hFF, 8'hFF, 8'hFF, 8'hE0, 8'hE0, 8'hE0, 8'hFF, 8'hFF, 8'h07};
  // Reported degrees and expected {high, low, critical, alert}; 70, 75 and 20 sit on the edges
  localparam int         AT [9] = '{50, 71, 70, 86, 80, 75, 74, 19, 20};
  localparam logic [3:0] AE [9] = '{4'h0, 4'h9, 4'h0, 4'hB, 4'hB, 4'hB, 4'h9, 4'h5, 4'h0};

  always #2.5 sys_clk = ~sys_clk;

  rtlr_regs rtlr_regs_inst (.sys_clk, .reset, .ce, .adc_valid, .adc_temp, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .alert_ack, .reg_rdata, .reg_rvalid, .high_alarm, .low_alarm, .crit_alarm, .alert_oe);
  rtlr_host_model rtlr_host_model_inst (.sys_clk, .reg_rdata, .reg_rvalid, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata);

  // Host view: offset added and clipped, then 16 degrees taken off and clipped again
  function automatic logic [10:0] exp_rd(input int x, input int o);
    int s;
    s = x + o;
    if (s > 1023) s = 1023;
    if (s < -1024) s = -1024;
    s = s - 128;
    if (s < -1024) s = -1024;
    return s[10:0];
  endfunction : exp_rd

  task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    rtlr_host_model_inst.wr(a, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] x);
    logic [7:0] d;
    logic       ok;
    rtlr_host_model_inst.rd(a, d, ok);
    chk({2'b00, ok, d}, {3'b001, x}, $sformatf("read %h", a));
  endtask : rd_chk

  task automatic al_chk(input logic [3:0] x);
    chk({7'h00, high_alarm, low_alarm, crit_alarm, alert_oe}, {7'h00, x}, "alarms");
  endtask : al_chk

  // One-cycle alert response pulse
  task automatic ack_pulse();
    @(posedge sys_clk);
    #1;
    alert_ack = 1'b1;
    @(posedge sys_clk);
    #1;
    alert_ack = 1'b0;
  endtask : ack_pulse

  // One converter result, then enough edges for reading, alarms and a latched alert to land
  task automatic sample(input int t);
    @(posedge sys_clk);
    #1;
    adc_valid = 1'b1;
    adc_temp  = t[10:0];
    @(posedge sys_clk);
    #1;
    adc_valid = 1'b0;
    adc_temp  = ~t[10:0];
    repeat (4) @(posedge sys_clk);
    #1;
  endtask : sample

  task automatic do_reset();
    @(posedge sys_clk);
    #1;
    reset = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    reset = 1'b0;
  endtask : do_reset

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  // Hang guard; the sequence needs under two thousand cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      $display("[ERR] %0t run did not finish", $time);
      tally_and_finish();
    end
  end

  initial begin
    int unsigned d;
    int          o, x;
    void'($urandom(62482));
    do_reset();
    // Reset values, the empty capture and an unmapped place
    for (int i = 0; i < 9; i++) rd_chk(RA[i], RV[i]);
    rd_chk(`RTLR_A_TEMP_FRAC, 8'h00);
    rd_chk(8'h5A, 8'h00);
    // A write offered while ce is low must not land
    ce = 1'b0;
    wr(`RTLR_A_CRIT, 8'h11);
    ce = 1'b1;
    rd_chk(`RTLR_A_CRIT, 8'h55);
    // Writable places keep only their implemented bits; the reading ignores writes
    for (int i = 0; i < 9; i++) begin
      d = $urandom;
      wr(RA[i], d[7:0]);
      rd_chk(RA[i], d[7:0] & RM[i]);
    end
    wr(`RTLR_A_TEMP_INT, 8'hA5);
    rd_chk(`RTLR_A_TEMP_INT, 8'h00);
    do_reset();
    // Offset plus converter result, both saturation corners first
    for (int i = 0; i < 8; i++) begin
      o = (i == 0) ? 1023 : (i == 1) ? -1024 : int'($urandom_range(0, 511)) - 256;
      x = (i == 0) ? 1023 : (i == 1) ? -1024 : int'($urandom_range(0, 2047)) - 1024;
      wr(`RTLR_A_OFF_INT, o[10:3]);
      wr(`RTLR_A_OFF_FRAC, {o[2:0], 5'h1F});
      sample(x);
      e = exp_rd(x, o);
      rd_chk(`RTLR_A_TEMP_INT, e[10:3]);
      if (i == 7) sample(x ^ 5);
      rd_chk(`RTLR_A_TEMP_FRAC, {e[2:0], 5'h00});
    end
    // Each filter code: the first sample loads, the second moves by that code's step
    for (int m = 0; m < 4; m++) begin
      do_reset();
      wr(`RTLR_A_CFG, 8'(m << 1));
      sample(256);
      sample(520);
      x = (m == 0) ? 520 : 256 + (264 >> ((m == 3) ? 3 : 1));
      e = exp_rd(x, 0);
      rd_chk(`RTLR_A_TEMP_INT, e[10:3]);
      rd_chk(`RTLR_A_TEMP_FRAC, {e[2:0], 5'h00});
    end
    // Comparator mode walks through the high and low limit edges and the hysteresis band
    do_reset();
    wr(`RTLR_A_CFG, 8'h01);
    wr(`RTLR_A_LOW_INT, 8'h14);
    for (int i = 0; i < 9; i++) begin
      sample((AT[i] + 16) * 8);
      al_chk(AE[i]);
    end
    // Interrupt mode: clear the latch left by the comparator walk, then latch afresh until the response
    wr(`RTLR_A_CFG, 8'h00);
    ack_pulse();
    al_chk(4'h0);
    sample((71 + 16) * 8);
    al_chk(4'h9);
    sample((50 + 16) * 8);
    al_chk(4'h1);
    ack_pulse();
    al_chk(4'h0);
    // A lowered critical limit takes effect at once
    wr(`RTLR_A_CRIT, 8'h3C);
    sample((61 + 16) * 8);
    al_chk(4'h3);
    tally_and_finish();
  end
endmodule : rtlr_regs_tb
